// ### mfcb_bank.sv
// Fault settings register and the lock, supply and zero-duty logic it steers.
// Sense inputs come from on-chip logic on sys_clk, so none is synchronised.
//
// What this block does
// RULE_01 - Abnormal-speed lock detector runs only while its enable bit is set.
// RULE_02 - Loss-of-sync lock detector runs only while its enable bit is set.
// RULE_03 - No-motor lock detector runs only while its enable bit is set.
// RULE_04 - Abnormal speed threshold is 250 Hz times code plus one.
// RULE_05 - Loss-of-sync fault after code plus two sync losses.
// RULE_06 - No-motor threshold picks one of eight sense voltages.
// RULE_07 - Overvoltage latches, or clears itself when the auto bit is set.
// RULE_08 - Maximum supply: none, or 20 V to 40 V in 5 V steps.
// RULE_09 - Undervoltage latches, or clears itself when the auto bit is set.
// RULE_10 - Minimum supply: none, or one of seven listed voltages.
// RULE_11 - Automatic retries limited to the coded count, code 0 unlimited.
// RULE_12 - Lock fault when speed falls below the coded minimum.
// RULE_13 - Abnormal-speed lock when speed jumps by more than the coded ratio.
// RULE_14 - Target speed is zero while duty is below the coded threshold.
// RULE_15 - Register at offset 94h, resets to zero, fully read/write.
// RULE_16 - Detected lock acts as the lock action mode selects.
// RULE_17 - Auto-recovery modes retry after the selected retry delay.
// RULE_18 - Bit 31 is stored as a plain parity bit with no effect.
module mfcb_bank
   import mfcb_pkg::*;
#(
   parameter int unsigned RETRY_CYC_PER_MS = CYC_PER_MS
)(
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rstn,
   // Register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic        reg_wr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_rd,
   output logic [31:0]      reg_rdata,
   // Motor state from the commutation engine
   input  wire logic        motor_run,
   input  wire logic        cycle_done,
   input  wire logic [15:0] speed_half_hz,
   input  wire logic        sync_lost,
   input  wire logic [7:0]  sense_half_mv,
   input  wire logic [9:0]  supply_dv,
   input  wire logic [9:0]  duty_permille,
   // Neighbouring lock settings and software clear
   input  wire logic [3:0]  lock_action_mode,
   input  wire logic [2:0]  lock_retry_time,
   input  wire logic        fault_clear,
   // Fault status and drive control
   output logic             lock_abn,
   output logic             lock_sync,
   output logic             lock_nomtr,
   output logic             lock_minspd,
   output logic             ov_fault,
   output logic             uv_fault,
   output logic             target_zero,
   output logic [1:0]       gate_mode,
   output logic             drive_off,
   output logic             retry_spent,
   output logic             fault_out_n
);

   typedef enum logic [1:0] {LK_CLEAR, LK_LATCHED, LK_WAIT} mfcb_lk_t;

   logic [1:0]  rst_sync_ff;
   logic        rst_n;
   logic [31:0] cfg_ff, nxt_cfg, rdata_ff, nxt_rdata;
   logic [15:0] abn_thr, minspd_lim, prev_spd_ff, nxt_prev_spd;
   logic [3:0]  sync_need, ratio_mul, sync_cnt_ff, nxt_sync_cnt;
   logic [7:0]  nomtr_lim;
   logic [9:0]  maxv_lim, minv_lim, duty_lim;
   logic [4:0]  retry_max, retry_cnt_ff, nxt_retry_cnt;
   logic        maxv_on;
   logic [19:0] jump_lim;
   logic        hit_abn, hit_sync, hit_nomtr, hit_minspd, any_hit;
   logic        ov_now, uv_now;
   mfcb_lk_t    st_ff, nxt_st;
   logic [31:0] wait_ff, nxt_wait;
   logic        abn_ff, sync_ff, nomtr_ff, minspd_ff;
   logic        nxt_abn, nxt_sync, nxt_nomtr, nxt_minspd;
   logic        ov_ff, uv_ff, zero_ff, off_ff, spent_ff, fo_n_ff;
   logic        nxt_ov, nxt_uv, nxt_zero, nxt_off, nxt_spent, nxt_fo_n;
   logic [1:0]  gate_ff, nxt_gate;
   logic        lock_on;

   // Reset release through two stages so every flop on rst_n leaves reset together
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         rst_sync_ff <= 2'h0;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_ff[1];

   mfcb_decode u_decode (
      .cfg        (cfg_ff),
      .abn_thr    (abn_thr),
      .sync_need  (sync_need),
      .nomtr_lim  (nomtr_lim),
      .maxv_on    (maxv_on),
      .maxv_lim   (maxv_lim),
      .minv_lim   (minv_lim),
      .retry_max  (retry_max),
      .minspd_lim (minspd_lim),
      .ratio_mul  (ratio_mul),
      .duty_lim   (duty_lim)
   );

   // Register write and read; parity bit is stored like any other bit
   always_comb begin
      nxt_cfg   = cfg_ff;
      nxt_rdata = rdata_ff;
      if (reg_wr && reg_addr == FC2_OFFSET) begin
         nxt_cfg = reg_wdata; // RULE_15 RULE_18
      end
      if (reg_rd) begin
         nxt_rdata = (reg_addr == FC2_OFFSET) ? cfg_ff : RD_UNMAPPED;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_ff   <= FC2_RESET;
         rdata_ff <= RD_UNMAPPED;
      end else begin
         cfg_ff   <= nxt_cfg;
         rdata_ff <= nxt_rdata;
      end
   end

   // Detectors; speed checks only look at a freshly measured cycle
   assign jump_lim  = {4'h0, prev_spd_ff} * {16'h0000, ratio_mul};
   assign hit_abn   = cfg_ff[ABN_EN_BIT] && motor_run && cycle_done && // RULE_01
                      (speed_half_hz > abn_thr || // RULE_04
                       (prev_spd_ff != 16'h0000 &&
                        {4'h0, speed_half_hz} > jump_lim)); // RULE_13
   assign hit_sync  = cfg_ff[SYNC_EN_BIT] && motor_run && sync_lost && // RULE_02
                      (sync_cnt_ff + 4'h1 >= sync_need); // RULE_05
   assign hit_nomtr = cfg_ff[NOMTR_EN_BIT] && motor_run && // RULE_03
                      sense_half_mv < nomtr_lim; // RULE_06
   assign hit_minspd = motor_run && cycle_done &&
                       speed_half_hz < minspd_lim; // RULE_12
   assign any_hit   = hit_abn | hit_sync | hit_nomtr | hit_minspd;
   assign lock_on   = lock_action_mode <= LM_REPORT;

   // Supply window; code 0 and unused codes leave that side unlimited
   assign ov_now = maxv_on && supply_dv > maxv_lim; // RULE_08
   assign uv_now = minv_lim != 10'h000 && supply_dv < minv_lim; // RULE_10

   // Lock flags and latched supply faults are sticky until cleared; target_zero follows duty; a new hit beats a clear in one cycle
   always_comb begin
      nxt_prev_spd = cycle_done ? speed_half_hz : prev_spd_ff;
      if (!motor_run) begin
         nxt_prev_spd = 16'h0000;
      end
      nxt_sync_cnt = sync_cnt_ff;
      if (!motor_run || fault_clear || hit_sync) begin
         nxt_sync_cnt = 4'h0;
      end else if (cfg_ff[SYNC_EN_BIT] && sync_lost) begin
         nxt_sync_cnt = sync_cnt_ff + 4'h1; // RULE_05
      end
      nxt_abn    = (hit_abn && lock_on) | (abn_ff & ~fault_clear);
      nxt_sync   = (hit_sync && lock_on) | (sync_ff & ~fault_clear);
      nxt_nomtr  = (hit_nomtr && lock_on) | (nomtr_ff & ~fault_clear);
      nxt_minspd = (hit_minspd && lock_on) | (minspd_ff & ~fault_clear);
      nxt_ov = ov_now | (ov_ff & ~(cfg_ff[OV_MODE_BIT] | fault_clear)); // RULE_07
      nxt_uv = uv_now | (uv_ff & ~(cfg_ff[UV_MODE_BIT] | fault_clear)); // RULE_09
      nxt_zero = duty_permille < duty_lim; // RULE_14
   end

   // Lock action; mode chosen at the moment of the lock holds until it ends
   always_comb begin
      nxt_st        = st_ff;
      nxt_wait      = wait_ff;
      nxt_retry_cnt = fault_clear ? 5'h00 : retry_cnt_ff;
      nxt_gate      = gate_ff;
      nxt_spent     = spent_ff & ~fault_clear;
      case (st_ff)
         LK_CLEAR: begin
            if (any_hit && lock_action_mode <= LM_LATCH_LAST) begin
               nxt_st   = LK_LATCHED; // RULE_16
               nxt_gate = lock_action_mode[1:0];
            end else if (any_hit && lock_action_mode <= LM_AUTO_LAST) begin
               nxt_gate = lock_action_mode[1:0];
               if (retry_max != 5'h00 && retry_cnt_ff >= retry_max) begin
                  nxt_st    = LK_LATCHED; // RULE_11
                  nxt_spent = 1'b1;
               end else begin
                  nxt_st        = LK_WAIT; // RULE_16
                  nxt_retry_cnt = retry_cnt_ff + 5'h01;
                  nxt_wait      = 32'(retry_ms(lock_retry_time) *
                                      RETRY_CYC_PER_MS); // RULE_17
               end
            end
         end
         LK_LATCHED: begin
            if (fault_clear) begin
               nxt_st = LK_CLEAR;
            end
         end
         LK_WAIT: begin
            if (wait_ff <= 32'h0000_0001) begin
               nxt_st   = LK_CLEAR; // RULE_17
               nxt_wait = 32'h0000_0000;
            end else begin
               nxt_wait = wait_ff - 32'h0000_0001;
            end
         end
         default: nxt_st = LK_CLEAR;
      endcase
      // Drive stays off while locked or outside the supply window
      nxt_off  = (nxt_st != LK_CLEAR) | nxt_ov | nxt_uv;
      nxt_fo_n = ~(nxt_off | nxt_abn | nxt_sync | nxt_nomtr | nxt_minspd);
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_spd_ff  <= 16'h0000;
         sync_cnt_ff  <= 4'h0;
         abn_ff       <= 1'b0;
         sync_ff      <= 1'b0;
         nomtr_ff     <= 1'b0;
         minspd_ff    <= 1'b0;
         ov_ff        <= 1'b0;
         uv_ff        <= 1'b0;
         zero_ff      <= 1'b0;
         st_ff        <= LK_CLEAR;
         wait_ff      <= 32'h0000_0000;
         retry_cnt_ff <= 5'h00;
         gate_ff      <= 2'h0;
         spent_ff     <= 1'b0;
         off_ff       <= 1'b0;
         fo_n_ff      <= 1'b1;
      end else begin
         prev_spd_ff  <= nxt_prev_spd;
         sync_cnt_ff  <= nxt_sync_cnt;
         abn_ff       <= nxt_abn;
         sync_ff      <= nxt_sync;
         nomtr_ff     <= nxt_nomtr;
         minspd_ff    <= nxt_minspd;
         ov_ff        <= nxt_ov;
         uv_ff        <= nxt_uv;
         zero_ff      <= nxt_zero;
         st_ff        <= nxt_st;
         wait_ff      <= nxt_wait;
         retry_cnt_ff <= nxt_retry_cnt;
         gate_ff      <= nxt_gate;
         spent_ff     <= nxt_spent;
         off_ff       <= nxt_off;
         fo_n_ff      <= nxt_fo_n;
      end
   end

   // Outputs straight from flops
   assign reg_rdata   = rdata_ff;
   assign lock_abn    = abn_ff;
   assign lock_sync   = sync_ff;
   assign lock_nomtr  = nomtr_ff;
   assign lock_minspd = minspd_ff;
   assign ov_fault    = ov_ff;
   assign uv_fault    = uv_ff;
   assign target_zero = zero_ff;
   assign gate_mode   = gate_ff;
   assign drive_off   = off_ff;
   assign retry_spent = spent_ff;
   assign fault_out_n = fo_n_ff;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   abn_enable_a: assert property ($rose(abn_ff) |-> $past(cfg_ff[ABN_EN_BIT]))
      else $error("abnormal speed flag rose while disabled"); // RULE_01
   sync_enable_a: assert property ($rose(sync_ff) |-> $past(cfg_ff[SYNC_EN_BIT]))
      else $error("sync loss flag rose while disabled"); // RULE_02
   nomtr_enable_a: assert property
      ($rose(nomtr_ff) |-> $past(cfg_ff[NOMTR_EN_BIT]))
      else $error("no motor flag rose while disabled"); // RULE_03
   sync_count_a: assert property
      ($rose(sync_ff) |-> $past(sync_cnt_ff) + 4'h1 >= $past(sync_need))
      else $error("sync loss fault before count reached"); // RULE_05
   reg_write_a: assert property
      (reg_wr && reg_addr == FC2_OFFSET |=> cfg_ff == $past(reg_wdata))
      else $error("register write not stored"); // RULE_15
   reg_read_a: assert property
      (reg_rd && reg_addr == FC2_OFFSET |=> reg_rdata == $past(cfg_ff))
      else $error("register read wrong"); // RULE_15
   ov_latch_a: assert property
      (ov_ff && !cfg_ff[OV_MODE_BIT] && !fault_clear |=> ov_ff)
      else $error("latched overvoltage dropped"); // RULE_07
   uv_auto_a: assert property (cfg_ff[UV_MODE_BIT] && !uv_now |=> !uv_ff)
      else $error("undervoltage did not self clear"); // RULE_09
   minspd_hit_a: assert property (hit_minspd && lock_on |=> minspd_ff)
      else $error("minimum speed lock missed"); // RULE_12
   zero_duty_a: assert property
      (duty_permille < duty_lim |=> target_zero)
      else $error("zero duty not flagged"); // RULE_14
   latch_hold_a: assert property
      (st_ff == LK_LATCHED && !fault_clear |=> st_ff == LK_LATCHED && drive_off)
      else $error("latched lock released early"); // RULE_16

endmodule

// ### mfcb_pkg.sv
// Constants, field layout and threshold tables for the fault settings bank.
// Assumes the sensing front end reports values in the units named below.
package mfcb_pkg;

   // Clock and timing
   localparam int unsigned CLK_HZ    = 25_000_000;
   localparam int unsigned MS_PER_S  = 1000;
   localparam int unsigned CYC_PER_MS = CLK_HZ / MS_PER_S;

   // Register placement and reset
   localparam logic [7:0]  FC2_OFFSET = 8'h94;
   localparam logic [31:0] FC2_RESET  = 32'h0000_0000;
   localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

   // Field positions
   localparam int PARITY_BIT  = 31;
   localparam int ABN_EN_BIT  = 30;
   localparam int SYNC_EN_BIT = 29;
   localparam int NOMTR_EN_BIT = 28;
   localparam int ABN_THR_LSB = 24;
   localparam int SYNC_CNT_LSB = 21;
   localparam int NOMTR_LSB   = 18;
   localparam int OV_MODE_BIT = 17;
   localparam int MAXV_LSB    = 14;
   localparam int UV_MODE_BIT = 13;
   localparam int MINV_LSB    = 10;
   localparam int RETRY_LSB   = 7;
   localparam int MINSPD_LSB  = 4;
   localparam int RATIO_LSB   = 2;
   localparam int DUTY_LSB    = 0;

   // Arithmetic coding (speed in 0.5 Hz, supply in 0.1 V, duty in 0.1 %)
   localparam logic [15:0] ABN_STEP     = 16'h01f4; // 250 Hz
   localparam logic [3:0]  SYNC_BASE    = 4'h2;
   localparam logic [9:0]  MAXV_BASE    = 10'h096;  // 15.0 V, code 0 unused
   localparam logic [9:0]  MAXV_STEP    = 10'h032;  // 5.0 V
   localparam logic [2:0]  MAXV_LAST    = 3'h5;
   localparam logic [9:0]  DUTY_BASE    = 10'h00a;  // 1.0 %
   localparam logic [9:0]  DUTY_STEP    = 10'h005;  // 0.5 %

   // Lock action mode coding
   localparam logic [3:0] LM_LATCH_LAST = 4'h3;
   localparam logic [3:0] LM_AUTO_LAST  = 4'h7;
   localparam logic [3:0] LM_REPORT     = 4'h8;

   // No-motor sense threshold in 0.5 mV units
   function automatic logic [7:0] nomtr_thr(input logic [2:0] c);
      case (c)
         3'h0: nomtr_thr = 8'h0a;
         3'h1: nomtr_thr = 8'h0f;
         3'h2: nomtr_thr = 8'h14;
         3'h3: nomtr_thr = 8'h19;
         3'h4: nomtr_thr = 8'h28;
         3'h5: nomtr_thr = 8'h32;
         3'h6: nomtr_thr = 8'h3c;
         default: nomtr_thr = 8'h50;
      endcase
   endfunction

   // Minimum supply in 0.1 V units, code 0 means no limit
   function automatic logic [9:0] minv_thr(input logic [2:0] c);
      case (c)
         3'h1: minv_thr = 10'h03c;
         3'h2: minv_thr = 10'h046;
         3'h3: minv_thr = 10'h050;
         3'h4: minv_thr = 10'h05a;
         3'h5: minv_thr = 10'h064;
         3'h6: minv_thr = 10'h078;
         3'h7: minv_thr = 10'h096;
         default: minv_thr = 10'h000;
      endcase
   endfunction

   // Retry attempt limit, code 0 means unlimited
   function automatic logic [4:0] retry_lim(input logic [2:0] c);
      case (c)
         3'h1: retry_lim = 5'h02;
         3'h2: retry_lim = 5'h03;
         3'h3: retry_lim = 5'h05;
         3'h4: retry_lim = 5'h07;
         3'h5: retry_lim = 5'h0a;
         3'h6: retry_lim = 5'h0f;
         3'h7: retry_lim = 5'h14;
         default: retry_lim = 5'h00;
      endcase
   endfunction

   // Minimum speed in 0.5 Hz units
   function automatic logic [15:0] minspd_thr(input logic [2:0] c);
      case (c)
         3'h0: minspd_thr = 16'h0001;
         3'h1: minspd_thr = 16'h0002;
         3'h2: minspd_thr = 16'h0004;
         3'h3: minspd_thr = 16'h0006;
         3'h4: minspd_thr = 16'h000a;
         3'h5: minspd_thr = 16'h0014;
         3'h6: minspd_thr = 16'h001e;
         default: minspd_thr = 16'h0032;
      endcase
   endfunction

   // Lock retry delay in ms
   function automatic logic [13:0] retry_ms(input logic [2:0] c);
      case (c)
         3'h0: retry_ms = 14'h0064;
         3'h1: retry_ms = 14'h01f4;
         3'h2: retry_ms = 14'h03e8;
         3'h3: retry_ms = 14'h07d0;
         3'h4: retry_ms = 14'h0bb8;
         3'h5: retry_ms = 14'h1388;
         3'h6: retry_ms = 14'h1d4c;
         default: retry_ms = 14'h2710;
      endcase
   endfunction

endpackage

// ### mfcb_decode.sv
// Turns the stored fault settings word into ready-to-compare thresholds.
// Purely combinational; the caller registers whatever it derives.
module mfcb_decode
   import mfcb_pkg::*;
(
   // Settings word
   input  wire logic [31:0] cfg,
   // Decoded thresholds
   output logic [15:0]      abn_thr,
   output logic [3:0]       sync_need,
   output logic [7:0]       nomtr_lim,
   output logic             maxv_on,
   output logic [9:0]       maxv_lim,
   output logic [9:0]       minv_lim,
   output logic [4:0]       retry_max,
   output logic [15:0]      minspd_lim,
   output logic [3:0]       ratio_mul,
   output logic [9:0]       duty_lim
);

   logic [3:0] abn_code;
   logic [2:0] maxv_code;
   logic [1:0] ratio_code;
   logic [1:0] duty_code;

   assign abn_code   = cfg[ABN_THR_LSB +: 4];
   assign maxv_code  = cfg[MAXV_LSB +: 3];
   assign ratio_code = cfg[RATIO_LSB +: 2];
   assign duty_code  = cfg[DUTY_LSB +: 2];

   // Linear fields: 250 Hz steps, count plus two, 5 V steps, 0.5 % steps
   assign abn_thr    = 16'(ABN_STEP * ({12'h000, abn_code} + 16'h0001));
   assign sync_need  = {1'b0, cfg[SYNC_CNT_LSB +: 3]} + SYNC_BASE;
   assign maxv_on    = (maxv_code != 3'h0) && (maxv_code <= MAXV_LAST);
   assign maxv_lim   = 10'(MAXV_BASE + MAXV_STEP * {7'h00, maxv_code});
   assign ratio_mul  = {1'b0, ratio_code, 1'b0} + 4'h2;
   assign duty_lim   = 10'(DUTY_BASE + DUTY_STEP * {8'h00, duty_code});

   // Irregular fields come from the shared tables
   assign nomtr_lim  = nomtr_thr(cfg[NOMTR_LSB +: 3]);
   assign minv_lim   = minv_thr(cfg[MINV_LSB +: 3]);
   assign retry_max  = retry_lim(cfg[RETRY_LSB +: 3]);
   assign minspd_lim = minspd_thr(cfg[MINSPD_LSB +: 3]);

endmodule

// ### tb.sv
// Self-checking bench for the fault settings bank: register port and sense.
// Assumes mfcb_bank with a short retry prescale; the bench drives all inputs.
module tb
   import mfcb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // Clock, reset and stimulus
   logic        sys_clk = 1'b0;
   logic        rstn;
   logic [7:0]  reg_addr;
   logic        reg_wr;
   logic [31:0] reg_wdata;
   logic        reg_rd;
   logic        motor_run;
   logic        cycle_done;
   logic [15:0] speed_half_hz;
   logic        sync_lost;
   logic [7:0]  sense_half_mv;
   logic [9:0]  supply_dv;
   logic [9:0]  duty_permille;
   logic [3:0]  lock_action_mode;
   logic [2:0]  lock_retry_time;
   logic        fault_clear;
   // Observed outputs
   logic [31:0] reg_rdata;
   logic        lock_abn, lock_sync, lock_nomtr, lock_minspd;
   logic        ov_fault, uv_fault, target_zero, drive_off;
   logic        retry_spent, fault_out_n;
   logic [1:0]  gate_mode;
   int          n_mismatch = 0;
   int          n_checks   = 0;
   // Expected thresholds, kept apart from the design's own tables
   logic [9:0]  minv_tab [8] = '{10'h000, 10'h03c, 10'h046, 10'h050,
                                 10'h05a, 10'h064, 10'h078, 10'h096};
   logic [7:0]  nomt_tab [8] = '{8'h0a, 8'h0f, 8'h14, 8'h19,
                                 8'h28, 8'h32, 8'h3c, 8'h50};
   logic [15:0] mspd_tab [8] = '{16'h0001, 16'h0002, 16'h0004, 16'h0006,
                                 16'h000a, 16'h0014, 16'h001e, 16'h0032};

   // Prescale of 2 keeps the 100 ms retry delay at 200 cycles
   mfcb_bank #(.RETRY_CYC_PER_MS(2)) dut (
      .sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .motor_run(motor_run),
      .cycle_done(cycle_done), .speed_half_hz(speed_half_hz),
      .sync_lost(sync_lost), .sense_half_mv(sense_half_mv),
      .supply_dv(supply_dv), .duty_permille(duty_permille),
      .lock_action_mode(lock_action_mode),
      .lock_retry_time(lock_retry_time), .fault_clear(fault_clear),
      .lock_abn(lock_abn), .lock_sync(lock_sync),
      .lock_nomtr(lock_nomtr), .lock_minspd(lock_minspd),
      .ov_fault(ov_fault), .uv_fault(uv_fault),
      .target_zero(target_zero), .gate_mode(gate_mode),
      .drive_off(drive_off), .retry_spent(retry_spent),
      .fault_out_n(fault_out_n));

   // 25 MHz system clock
   always #20 sys_clk = ~sys_clk;

   // Waits past n edges so that their updates have landed
   task automatic wt(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chkb(input string nm, input logic e, input logic g);
      n_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value %s expected %b seen %b", nm, e, g);
      end
   endtask

   // Register write: strobe for exactly one edge
   task automatic wr(input logic [31:0] d, input logic [7:0] a = 8'h94);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      wt(1);
      chk("reg_rdata", e, reg_rdata);
   endtask

   // One electrical cycle report at the given speed
   task automatic spd(input logic [15:0] s);
      @(posedge sys_clk);
      speed_half_hz <= s;
      cycle_done <= 1'b1;
      @(posedge sys_clk);
      cycle_done <= 1'b0;
      wt(2);
   endtask

   task automatic syn();
      @(posedge sys_clk);
      sync_lost <= 1'b1;
      @(posedge sys_clk);
      sync_lost <= 1'b0;
   endtask

   task automatic clr();
      @(posedge sys_clk);
      fault_clear <= 1'b1;
      @(posedge sys_clk);
      fault_clear <= 1'b0;
      wt(2);
   endtask

   task automatic sup(input logic [9:0] v);
      @(posedge sys_clk);
      supply_dv <= v;
      wt(3);
   endtask

   task automatic sen(input logic [7:0] v);
      @(posedge sys_clk);
      sense_half_mv <= v;
      wt(3);
   endtask

   task automatic duty(input logic [9:0] v);
      @(posedge sys_clk);
      duty_permille <= v;
      wt(3);
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Watchdog: the sequence needs well under 10000 cycles
   initial begin
      #800000;
      n_mismatch++;
      end_of_test();
   end

   initial begin
      rstn = 1'b0;
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_wdata = 32'h0000_0000;
      reg_rd = 1'b0;
      motor_run = 1'b1;
      cycle_done = 1'b0;
      speed_half_hz = 16'h0064;
      sync_lost = 1'b0;
      sense_half_mv = 8'hff;
      supply_dv = 10'h078;
      duty_permille = 10'h3e8;
      lock_action_mode = 4'h0;
      lock_retry_time = 3'h0;
      fault_clear = 1'b0;
      repeat (16) @(posedge sys_clk);
      rstn <= 1'b1;
      wt(3);
      // Register reset value, access, unmapped offsets, free parity bit
      rd(8'h94, 32'h0000_0000);
      wr(32'hffff_ffff);
      rd(8'h94, 32'hffff_ffff);
      wr(32'h0000_0000, 8'h96);
      rd(8'h94, 32'hffff_ffff);
      rd(8'h96, 32'h0000_0000);
      wr(32'h8000_0000);
      clr();
      rd(8'h94, 32'h8000_0000);
      chkb("fault_out_n", 1'b1, fault_out_n);
      // Zero-duty threshold, one step below and at each code
      for (int c = 0; c < 4; c++) begin
         wr(32'(c));
         duty(10'(10 + 5 * c));
         chkb("target_zero", 1'b0, target_zero);
         duty(10'(9 + 5 * c));
         chkb("target_zero", 1'b1, target_zero);
      end
      duty(10'h3e8);
      // Overvoltage: compare is strict, latched fault needs a clear
      for (int c = 1; c < 6; c++) begin
         wr(32'(c) << MAXV_LSB);
         sup(10'(150 + 50 * c));
         chkb("ov_fault", 1'b0, ov_fault);
         sup(10'(151 + 50 * c));
         chkb("ov_fault", 1'b1, ov_fault);
         sup(10'h078);
         chkb("ov_fault", 1'b1, ov_fault);
         clr();
         chkb("ov_fault", 1'b0, ov_fault);
      end
      wr((32'h5 << MAXV_LSB) | (32'h1 << OV_MODE_BIT));
      sup(10'h191);
      chkb("drive_off", 1'b1, drive_off);
      sup(10'h078);
      chkb("ov_fault", 1'b0, ov_fault);
      for (int c = 6; c < 9; c++) begin
         wr(32'(c % 8) << MAXV_LSB);
         sup(10'h3ff);
         chkb("ov_fault", 1'b0, ov_fault);
      end
      // Undervoltage with the supply parked above every minimum
      sup(10'h0c8);
      for (int c = 1; c < 8; c++) begin
         wr(32'(c) << MINV_LSB);
         sup(minv_tab[c]);
         chkb("uv_fault", 1'b0, uv_fault);
         sup(minv_tab[c] - 10'h001);
         chkb("uv_fault", 1'b1, uv_fault);
         sup(10'h0c8);
         chkb("uv_fault", 1'b1, uv_fault);
         clr();
      end
      wr((32'h7 << MINV_LSB) | (32'h1 << UV_MODE_BIT));
      sup(10'h095);
      chkb("uv_fault", 1'b1, uv_fault);
      sup(10'h0c8);
      chkb("uv_fault", 1'b0, uv_fault);
      wr(32'h0000_0000);
      sup(10'h000);
      chkb("uv_fault", 1'b0, uv_fault);
      sup(10'h078);
      // Loss of sync: disabled, then one short of and at each count
      repeat (10) syn();
      wt(2);
      chkb("lock_sync", 1'b0, lock_sync);
      clr();
      for (int c = 0; c < 8; c++) begin
         wr((32'h1 << SYNC_EN_BIT) | (32'(c) << SYNC_CNT_LSB));
         repeat (c + 1) syn();
         wt(2);
         chkb("lock_sync", 1'b0, lock_sync);
         syn();
         wt(2);
         chkb("lock_sync", 1'b1, lock_sync);
         clr();
      end
      // No motor: disabled, then at and below each sense threshold
      wr(32'h0000_0000);
      sen(8'h00);
      chkb("lock_nomtr", 1'b0, lock_nomtr);
      for (int c = 0; c < 8; c++) begin
         sen(8'hff);
         clr();
         wr((32'h1 << NOMTR_EN_BIT) | (32'(c) << NOMTR_LSB));
         sen(nomt_tab[c]);
         chkb("lock_nomtr", 1'b0, lock_nomtr);
         sen(nomt_tab[c] - 8'h01);
         chkb("lock_nomtr", 1'b1, lock_nomtr);
      end
      sen(8'hff);
      clr();
      // Speed jump: equal to the ratio passes, one above it locks
      for (int r = 0; r < 4; r++) begin
         wr((32'h1 << ABN_EN_BIT) | (32'hf << ABN_THR_LSB) | (32'(r) << 2));
         spd(16'h000a);
         spd(16'(20 * (r + 1)));
         chkb("lock_abn", 1'b0, lock_abn);
         spd(16'(40 * (r + 1) * (r + 1) + 1));
         chkb("lock_abn", 1'b1, lock_abn);
         clr();
      end
      wr(32'h0000_0000);
      spd(16'hffff);
      chkb("lock_abn", 1'b0, lock_abn);
      // Abnormal speed threshold; ratio 8 keeps the jump check quiet
      for (int k = 0; k < 16; k++) begin
         wr((32'h1 << ABN_EN_BIT) | (32'(k) << ABN_THR_LSB) | 32'hc);
         spd(16'(500 * (k + 1)));
         chkb("lock_abn", 1'b0, lock_abn);
         spd(16'(500 * (k + 1) + 1));
         chkb("lock_abn", 1'b1, lock_abn);
         clr();
      end
      // Minimum speed at and just below each code
      for (int c = 0; c < 8; c++) begin
         wr(32'(c) << MINSPD_LSB);
         spd(mspd_tab[c]);
         chkb("lock_minspd", 1'b0, lock_minspd);
         spd(mspd_tab[c] - 16'h0001);
         chkb("lock_minspd", 1'b1, lock_minspd);
         clr();
      end
      // Lock action modes 0 to 9; the long wait lets a pending retry end
      wr(32'h0000_0000);
      for (int m = 0; m < 10; m++) begin
         @(posedge sys_clk);
         lock_action_mode <= 4'(m);
         spd(16'h0000);
         chkb("lock_minspd", m < 9, lock_minspd);
         chkb("drive_off", m < 8, drive_off);
         chkb("fault_out_n", m > 8, fault_out_n);
         if (m < 8) begin
            chk("gate_mode", 32'(m % 4), 32'(gate_mode));
         end
         clr();
         wt(210);
      end
      // Auto retry limited to two attempts; 500 ms delay is 1000 cycles here
      @(posedge sys_clk);
      lock_action_mode <= 4'h4;
      lock_retry_time <= 3'h1;
      wr(32'h1 << RETRY_LSB);
      for (int i = 0; i < 3; i++) begin
         spd(16'h0000);
         wt(997);
         chkb("drive_off", 1'b1, drive_off);
         wt(1);
         chkb("drive_off", i == 2, drive_off);
         chkb("retry_spent", i == 2, retry_spent);
      end
      end_of_test();
   end
endmodule
